/* common/phy_irq_cfg.svh */
// register offsets, field positions and frame counts for the phy status block
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

`define REG_CSI          5'h1B
`define REG_FLAGS        5'h1D
`define REG_MASK         5'h1E
`define REG_SPECIAL      5'h1F

`define POL_BIT          4
`define NEG_DONE_BIT     12
`define SPD_LSB          2
`define SPD_MSB          4
`define FLAG_LSB         1
`define FLAG_MSB         10

`define F_TX_OVERFLOW    10
`define F_TX_UNDERFLOW   9
`define F_IDLE_OVERFLOW  8
`define F_ENERGY         7
`define F_NEG_COMPLETE   6
`define F_REMOTE_FAULT   5
`define F_LINK_DOWN      4
`define F_PARTNER_ACK    3
`define F_CONFIG_FAULT   2
`define F_PAGE_RECEIVED  1

`define PREAMBLE_LEN     6'h20
`define HDR_LAST         4'hC
`define TA_LAST          1'h1
`define DATA_LAST        4'hF
`define OP_READ          2'h2
`define OP_WRITE         2'h1
`define WORD_ZERO        16'h0000

`endif

/* common/phy_irq_pkg.sv */
// types shared by the phy interrupt and status registers
package phy_irq_pkg;

  typedef struct packed {
    logic       reversed_polarity_10m;
    logic       energy_present;
    logic       link_up;
    logic       negotiation_done;
    logic [2:0] resolved_speed_duplex;
  } phy_status_t;

  typedef struct packed {
    logic tx_overflow;
    logic tx_underflow;
    logic idle_error_overflow;
    logic remote_fault;
    logic partner_ack;
    logic parallel_fault;
    logic ms_config_fault;
    logic page_received;
  } phy_events_t;

  typedef enum logic [4:0] {
    ST_PRE  = 5'h01,
    ST_HDR  = 5'h02,
    ST_TA   = 5'h04,
    ST_DATA = 5'h08,
    ST_SPARE = 5'h10
  } smi_state_t;

endpackage : phy_irq_pkg

/* core/phy_interrupt_status_regs.sv */
// interrupt source, mask and status registers behind the serial management port
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - csi bit 4 shows reversed 10M polarity
// - flag 10 latches transmit buffer overflow
// - flag 9 latches transmit buffer underflow
// - flag 8 latches idle error overflow
// - flag 7 latches energy present rising
// - flag 6 latches negotiation complete
// - flag 5 latches remote fault
// - flag 4 latches link going down
// - flag 3 latches partner acknowledge
// - flag 2 latches parallel or config fault
// - flag 1 latches page received; rest reserved
// - mask bits 10..1 enable sources, reset 0
// - special bit 12 shows negotiation done
// - reading register 31 clears nothing
// - special bits 4:2 give speed/duplex
// - speed field follows negotiation outcome
`include "phy_irq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module phy_interrupt_status_regs
  import phy_irq_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        MDC,
  input  wire logic        MDIO_I,
  output logic             MDIO_O,
  output logic             MDIO_OE,
  input  wire logic [4:0]  PHY_ADDR,
  input  wire phy_status_t STATUS,
  input  wire phy_events_t EVENTS,
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  logic [1:0] mdc_sync;
  logic [1:0] mdio_sync;
  logic       mdc_prev;
  logic [4:0] addr_meta;
  logic [4:0] phy_addr;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mdc_sync  <= 2'h0;
      mdio_sync <= 2'h0;
      mdc_prev  <= 1'b0;
      addr_meta <= 5'h00;
      phy_addr  <= 5'h00;
    end else begin
      mdc_sync  <= {mdc_sync[0], MDC};
      mdio_sync <= {mdio_sync[0], MDIO_I};
      mdc_prev  <= mdc_sync[1];
      addr_meta <= PHY_ADDR;
      phy_addr  <= addr_meta;
    end
  end

  wire mdc_rise = mdc_sync[1] & ~mdc_prev;
  wire mdio_bit = mdio_sync[1];

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic        energy_prev;
  logic        link_prev;
  logic        neg_prev;
  logic [10:1] flags;
  logic [10:1] enables;
  logic [10:1] set_vec;
  logic [10:1] clr_vec;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      energy_prev <= 1'b0;
      link_prev   <= 1'b0;
      neg_prev    <= 1'b0;
    end else begin
      energy_prev <= STATUS.energy_present;
      link_prev   <= STATUS.link_up;
      neg_prev    <= STATUS.negotiation_done;
    end
  end

  assign set_vec[`F_TX_OVERFLOW]   = EVENTS.tx_overflow;
  assign set_vec[`F_TX_UNDERFLOW]  = EVENTS.tx_underflow;
  assign set_vec[`F_IDLE_OVERFLOW] = EVENTS.idle_error_overflow;
  assign set_vec[`F_ENERGY]        = STATUS.energy_present & ~energy_prev;
  assign set_vec[`F_NEG_COMPLETE]  = STATUS.negotiation_done & ~neg_prev;
  assign set_vec[`F_REMOTE_FAULT]  = EVENTS.remote_fault;
  assign set_vec[`F_LINK_DOWN]     = link_prev & ~STATUS.link_up;
  assign set_vec[`F_PARTNER_ACK]   = EVENTS.partner_ack;
  assign set_vec[`F_CONFIG_FAULT]  = EVENTS.parallel_fault | EVENTS.ms_config_fault;
  assign set_vec[`F_PAGE_RECEIVED] = EVENTS.page_received;

  // ----------------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------------
  smi_state_t  state;
  logic [5:0]  ones;
  logic [3:0]  cnt;
  logic [11:0] hdr;
  logic        is_read;
  logic [4:0]  reg_sel;
  logic [15:0] shift;
  logic        wr_stb;
  logic [4:0]  wr_reg;
  logic [15:0] wr_data;

  wire [12:0] next_hdr   = {hdr, mdio_bit};
  wire [1:0]  hdr_op     = next_hdr[11:10];
  wire        hdr_ok     = next_hdr[12] & (next_hdr[9:5] == phy_addr) &
                           ((hdr_op == `OP_READ) | (hdr_op == `OP_WRITE));
  wire [15:0] next_wdata = {wr_data[14:0], mdio_bit};

  wire [15:0] csi_word  = {11'h000, STATUS.reversed_polarity_10m, 4'h0};
  wire [15:0] flag_word = {5'h00, flags, 1'b0};
  wire [15:0] mask_word = {5'h00, enables, 1'b0};
  wire [15:0] spec_word = {3'h0, STATUS.negotiation_done, 7'h00,
                           STATUS.resolved_speed_duplex, 2'h0};
  // read path has no side effect
  wire [15:0] rd_data   = (reg_sel == `REG_CSI)     ? csi_word  :
                          (reg_sel == `REG_FLAGS)   ? flag_word :
                          (reg_sel == `REG_MASK)    ? mask_word :
                          (reg_sel == `REG_SPECIAL) ? spec_word : `WORD_ZERO;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_PRE;
      ones    <= 6'h00;
      cnt     <= 4'h0;
      hdr     <= 12'h000;
      is_read <= 1'b0;
      reg_sel <= 5'h00;
      shift   <= 16'h0000;
      MDIO_O  <= 1'b0;
      MDIO_OE <= 1'b0;
      wr_stb  <= 1'b0;
      wr_reg  <= 5'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state)
          ST_PRE: begin
            if (mdio_bit) begin
              if (ones != `PREAMBLE_LEN) ones <= ones + 6'h01;
            end else begin
              // a zero after a full preamble is the first start bit
              if (ones == `PREAMBLE_LEN) begin
                state <= ST_HDR;
                cnt   <= 4'h0;
              end
              ones <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr <= next_hdr[11:0];
            cnt <= cnt + 4'h1;
            // thirteen header bits: start, op, address, register
            if (cnt == `HDR_LAST) begin
              // frames for another address are ignored whole
              state   <= hdr_ok ? ST_TA : ST_PRE;
              is_read <= (hdr_op == `OP_READ);
              reg_sel <= next_hdr[4:0];
              wr_reg  <= next_hdr[4:0];
              cnt     <= 4'h0;
            end
          end
          ST_TA: begin
            cnt <= cnt + 4'h1;
            if (cnt[0] == `TA_LAST) begin
              state <= ST_DATA;
              cnt   <= 4'h0;
              if (is_read) begin
                shift  <= rd_data;
                MDIO_O <= rd_data[15];
              end
            end else if (is_read) begin
              MDIO_OE <= 1'b1;
              MDIO_O  <= 1'b0;
            end
          end
          ST_DATA: begin
            cnt     <= cnt + 4'h1;
            shift   <= {shift[14:0], 1'b0};
            MDIO_O  <= is_read ? shift[14] : 1'b0;
            wr_data <= next_wdata;
            if (cnt == `DATA_LAST) begin
              state   <= ST_PRE;
              MDIO_OE <= 1'b0;
              MDIO_O  <= 1'b0;
              wr_stb  <= ~is_read;
            end
          end
          default: begin
            state   <= ST_PRE;
            MDIO_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // flags and enables
  // ----------------------------------------------------------------
  wire flag_wr = wr_stb & (wr_reg == `REG_FLAGS);
  wire mask_wr = wr_stb & (wr_reg == `REG_MASK);

  genvar gi;
  generate
    for (gi = `FLAG_LSB; gi <= `FLAG_MSB; gi = gi + 1) begin : g_flag
      // write one clears; a coincident event wins
      assign clr_vec[gi] = flag_wr & wr_data[gi];
      always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
          flags[gi]   <= 1'b0;
          enables[gi] <= 1'b0;
        end else begin
          flags[gi] <= set_vec[gi] | (flags[gi] & ~clr_vec[gi]);
          if (mask_wr) enables[gi] <= wr_data[gi];
        end
      end
    end
  endgenerate

  assign IRQ = |(flags & enables);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_mask_write;
    mask_wr;
  endsequence

  property p_pol;
    @(posedge CLK_SYS) disable iff (!rst_n)
      reg_sel == `REG_CSI |-> rd_data[`POL_BIT] == STATUS.reversed_polarity_10m &&
                              rd_data[15:5] == 11'h000 && rd_data[3:0] == 4'h0;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bit wrong");

  property p_ovf;
    @(posedge CLK_SYS) disable iff (!rst_n)
      EVENTS.tx_overflow |=> flags[`F_TX_OVERFLOW];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");

  property p_hold;
    @(posedge CLK_SYS) disable iff (!rst_n)
      flags[`F_TX_UNDERFLOW] && !flag_wr |=> flags[`F_TX_UNDERFLOW];
  endproperty
  a_hold: assert property (p_hold) else $error("underflow flag dropped");

  property p_idle;
    @(posedge CLK_SYS) disable iff (!rst_n)
      EVENTS.idle_error_overflow |=> flags[`F_IDLE_OVERFLOW];
  endproperty
  a_idle: assert property (p_idle) else $error("idle overflow flag not set");

  property p_energy;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(STATUS.energy_present) |=> flags[`F_ENERGY];
  endproperty
  a_energy: assert property (p_energy) else $error("energy flag not set");

  property p_neg;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(STATUS.negotiation_done) |=> flags[`F_NEG_COMPLETE];
  endproperty
  a_neg: assert property (p_neg) else $error("negotiation flag not set");

  property p_link;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $fell(STATUS.link_up) |=> flags[`F_LINK_DOWN];
  endproperty
  a_link: assert property (p_link) else $error("link down flag not set");

  property p_ack;
    @(posedge CLK_SYS) disable iff (!rst_n)
      EVENTS.partner_ack |=> flags[`F_PARTNER_ACK];
  endproperty
  a_ack: assert property (p_ack) else $error("partner ack flag not set");

  property p_cfg;
    @(posedge CLK_SYS) disable iff (!rst_n)
      EVENTS.ms_config_fault |=> flags[`F_CONFIG_FAULT];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config fault flag not set");

  property p_page;
    @(posedge CLK_SYS) disable iff (!rst_n)
      EVENTS.page_received |=> flags[`F_PAGE_RECEIVED];
  endproperty
  a_page: assert property (p_page) else $error("page flag not set");

  property p_mask;
    @(posedge CLK_SYS) disable iff (!rst_n)
      s_mask_write |=> enables == $past(wr_data[10:1]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask write lost");

  property p_stable;
    @(posedge CLK_SYS) disable iff (!rst_n)
      !flag_wr && set_vec == 10'h000 |=> flags == $past(flags);
  endproperty
  a_stable: assert property (p_stable) else $error("flags changed without cause");

  property p_spec;
    @(posedge CLK_SYS) disable iff (!rst_n)
      reg_sel == `REG_SPECIAL |-> rd_data[`NEG_DONE_BIT] == STATUS.negotiation_done &&
                                  rd_data[`SPD_MSB:`SPD_LSB] == STATUS.resolved_speed_duplex;
  endproperty
  a_spec: assert property (p_spec) else $error("special status wrong");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (flags[`F_PAGE_RECEIVED] && enables[`F_PAGE_RECEIVED]) |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : phy_interrupt_status_regs

`default_nettype wire

/* dv/smi_ctrl_model.sv */
// station management controller model for the serial management port
`timescale 1ns/100ps
`default_nettype none

module smi_ctrl_model (
  input  wire logic CLK_SYS,
  output logic      mdc,
  output logic      mdio_i,
  input  wire logic mdio_o,
  input  wire logic mdio_oe
);
  logic drv = 1'b0;
  logic dval = 1'b1;
  int   half = 4;

  // a released line floats high through the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (drv ? dval : 1'b1);

  initial mdc = 1'b0;

  // data changes while clock is low, sampled just before the rise
  task automatic tick(input logic en, input logic b, output logic s);
    @(posedge CLK_SYS) #1;
    mdc = 1'b0;
    drv = en;
    dval = b;
    repeat (half) @(posedge CLK_SYS);
    #1 s = mdio_i;
    mdc = 1'b1;
    repeat (half) @(posedge CLK_SYS);
  endtask : tick

  // random half period gives prompt and slow management clocks
  task automatic frame(input logic [4:0] pa, input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] w;
    logic        s;
    half = 4 + $urandom_range(1);
    w = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    repeat (32) tick(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      tick(!(rd && i < 18), w[i], s);
      if (i < 16) q[i] = s;
    end
    #1 drv = 1'b0;
    repeat (12) @(posedge CLK_SYS);
  endtask : frame
endmodule : smi_ctrl_model

`default_nettype wire

/* dv/phy_interrupt_status_regs_bench.sv */
// self-checking bench for the phy interrupt and status registers
`include "phy_irq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module phy_interrupt_status_regs_bench
  import phy_irq_pkg::*;
;
  localparam logic [4:0] ADDR = 5'h05;
  logic        CLK_SYS;
  logic        NRST;
  logic        MDC;
  logic        MDIO_I;
  logic        MDIO_O;
  logic        MDIO_OE;
  logic        IRQ;
  phy_status_t STATUS;
  phy_events_t EVENTS;
  phy_status_t prev = '0;
  logic [15:0] q;
  logic [4:0]  regs[5] = '{`REG_CSI, `REG_FLAGS, `REG_MASK, `REG_SPECIAL, 5'h05};
  logic [2:0]  spd[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  int          num_errors = 0;
  int          compares = 0;
  int          flags = 0;
  int          mask = 0;

  phy_interrupt_status_regs dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .MDC(MDC), .MDIO_I(MDIO_I),
    .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .PHY_ADDR(ADDR), .STATUS(STATUS), .EVENTS(EVENTS), .IRQ(IRQ));
  smi_ctrl_model smi (.CLK_SYS(CLK_SYS), .mdc(MDC), .mdio_i(MDIO_I), .mdio_o(MDIO_O), .mdio_oe(MDIO_OE));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // edges of levels
  always @(posedge CLK_SYS) begin
    if (NRST) begin
      flags |= {EVENTS[7:5], STATUS.energy_present & ~prev.energy_present,
                STATUS.negotiation_done & ~prev.negotiation_done, EVENTS[4],
                ~STATUS.link_up & prev.link_up, EVENTS[3], |EVENTS[2:1], EVENTS[0], 1'b0};
    end
    prev = STATUS;
  end

  function automatic logic [15:0] want(input logic [4:0] ra);
    case (ra)
      `REG_CSI:     return {11'h000, STATUS.reversed_polarity_10m, 4'h0};
      `REG_FLAGS:   return flags[15:0] & 16'h07FE;
      `REG_MASK:    return mask[15:0] & 16'h07FE;
      `REG_SPECIAL: return {3'h0, STATUS.negotiation_done, 7'h00, STATUS.resolved_speed_duplex, 2'h0};
      default:      return 16'h0000;
    endcase
  endfunction : want

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic irq_ok();
    check("irq", {15'h0, (flags & mask & 32'h07FE) != 0}, {15'h0, IRQ});
  endtask : irq_ok

  task automatic rdc(input logic [4:0] ra);
    smi.frame(ADDR, 1'b1, ra, 16'h0000, q);
    check($sformatf("reg %h", ra), want(ra), q);
  endtask : rdc

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    smi.frame(ADDR, 1'b0, ra, d, q);
    if (ra == `REG_MASK) mask = d;
    if (ra == `REG_FLAGS) flags &= ~{16'h0000, d};
  endtask : wr

  // events and status change only between frames
  task automatic hit(input logic [7:0] ev, input phy_status_t st);
    @(posedge CLK_SYS) #1;
    EVENTS = ev;
    STATUS = st;
    @(posedge CLK_SYS) #1;
    EVENTS = 8'h00;
    @(posedge CLK_SYS) #1;
  endtask : hit

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial begin
    repeat (100000) @(posedge CLK_SYS);
    num_errors++;
    final_report();
  end

  initial begin
    NRST = 1'b0;
    EVENTS = '0;
    STATUS = '0;
    void'($urandom(76));
    repeat (4) @(posedge CLK_SYS);
    #1 NRST = 1'b1;
    repeat (4) @(posedge CLK_SYS);
    foreach (regs[i]) rdc(regs[i]);
    $display("reset values done");
    wr(`REG_MASK, 16'($urandom));
    rdc(`REG_MASK);
    wr(`REG_CSI, 16'hFFFF);
    wr(`REG_SPECIAL, 16'hFFFF);
    rdc(`REG_CSI);
    rdc(`REG_SPECIAL);
    $display("mask and read-only done");
    wr(`REG_MASK, 16'h0000);
    hit(8'h80, STATUS);
    irq_ok();
    rdc(`REG_FLAGS);
    wr(`REG_MASK, 16'hFFFF);
    irq_ok();
    for (int k = 0; k < 11; k++) begin
      if (k < 8) hit(8'h01 << k, STATUS);
      else hit(8'h00, k == 8 ? 7'h20 : (k == 9 ? 7'h18 : 7'h00));
      irq_ok();
      rdc(`REG_FLAGS);
      wr(`REG_FLAGS, q);
      rdc(`REG_FLAGS);
      irq_ok();
    end
    $display("sources done");
    for (int i = 0; i < 4; i++) begin
      hit(8'h00, {i[0], 2'h0, i[1], spd[i]});
      rdc(`REG_CSI);
      rdc(`REG_SPECIAL);
      rdc(`REG_SPECIAL);
      rdc(`REG_FLAGS);
    end
    $display("status done");
    wr(`REG_FLAGS, 16'h0000);
    rdc(`REG_FLAGS);
    smi.frame(ADDR ^ 5'h01, 1'b0, `REG_MASK, 16'h0000, q);
    smi.frame(ADDR ^ 5'h01, 1'b1, `REG_MASK, 16'h0000, q);
    check("foreign read", 16'hFFFF, q);
    rdc(`REG_MASK);
    $display("refusals done");
    for (int n = 0; n < 6; n++) begin
      hit(8'($urandom), 7'($urandom));
      wr(`REG_MASK, 16'($urandom));
      irq_ok();
      foreach (regs[i]) rdc(regs[i]);
      wr(`REG_FLAGS, 16'($urandom));
    end
    $display("random done");
    final_report();
  end
endmodule : phy_interrupt_status_regs_bench

`default_nettype wire
